// ==== npsr_regs.v ====
// Channel B oscillator presets 2 and 3, startup flag, die variant and supply noise enables.
// Assumes a byte-addressed register port from the serial control port decoder, same clock.
`timescale 1ns/1ps
`default_nettype none
`include "npsr_consts.vh"
// Operation
// - Preset 2 frequency is a 32-bit read/write word that resets to 0xC0000000.
// - Preset 3 frequency is a 32-bit read/write word at 0x258 that resets to 0xC0000000.
// - Preset 2 phase is a 16-bit read/write word at 0x254 that resets to zero.
// - Preset 3 phase is a 16-bit read/write word at 0x25C that resets to zero.
// - Bit 0 of the byte at 0x270 reads 1 only once initialization has finished.
// - Bits 4:0 of the byte at 0x297 hold the die variant code, bits 7:5 are reserved.
// - Bit 5 of the byte at 0x2A2 enables digital core supply noise suppression, reset 0.
// - Bit 4 of the byte at 0x2A2 enables second core supply noise suppression, reset 0.
// - In interleaved single-channel mode all channel B presets are ignored for channel A.
module npsr_regs #(
   parameter [4:0] DIE_VARIANT = 5'h15
) (
   // Clock and reset
   input  wire                   i_ref_clk,
   input  wire                   i_rstn,
   // Register port
   input  wire                   i_wr,
   input  wire                   i_rd,
   input  wire [11:0]            i_addr,
   input  wire [31:0]            i_wdata,
   input  wire [3:0]             i_be,
   output reg  [31:0]            o_rdata,
   output reg                    o_rvalid,
   // Device state
   input  wire                   i_init_done,
   input  wire                   i_single_channel,
   input  wire [1:0]             i_preset_sel,
   // Oscillator channel B presets as used
   output reg  [31:0]            o_nco_freq_b_preset2,
   output reg  [15:0]            o_nco_phase_b_preset2,
   output reg  [31:0]            o_nco_freq_b_preset3,
   output reg  [15:0]            o_nco_phase_b_preset3,
   output reg                    o_chan_b_presets_valid,
   // Supply noise enables
   output reg                    o_digital_core_supply_noise_suppress_en,
   output reg                    o_second_core_supply_noise_suppress_en
);
   // Startup, single-channel and preset select syncs, first stage read only by second
   reg         init_meta_q;
   reg         init_sync_q;
   reg         single_meta_q;
   reg         single_sync_q;
   reg  [1:0]  sel_meta_q;
   reg  [1:0]  sel_sync_q;
   reg  [7:0]  supply_q;
   reg  [7:0]  supply_d;
   reg  [31:0] rdata_d;
   wire [1:0]  word_sel;
   wire        word_hit;
   wire [31:0] freq2;
   wire [31:0] phase2;
   wire [31:0] freq3;
   wire [31:0] phase3;
   wire [3:0]  we_word;
   wire        supply_hit;
   wire        preset_hi;

   assign word_hit   = (i_addr[11:4] == 8'h25);
   assign word_sel   = i_addr[3:2];
   assign we_word[0] = i_wr && word_hit && (word_sel == 2'h0);
   assign we_word[1] = i_wr && word_hit && (word_sel == 2'h1);
   assign we_word[2] = i_wr && word_hit && (word_sel == 2'h2);
   assign we_word[3] = i_wr && word_hit && (word_sel == 2'h3);
   assign supply_hit = i_wr && (i_addr == `NPSR_OFF_SUPPLY);
   assign preset_hi  = sel_sync_q[1];

   npsr_word_reg #(
      .RESET_VALUE (`NPSR_RST_FREQ),
      .WRITE_MASK  (32'hFFFFFFFF)
   ) u_freq2 (
      .i_ref_clk (i_ref_clk),
      .i_rstn    (i_rstn),
      .i_we      (we_word[0]),
      .i_be      (i_be),
      .i_wdata   (i_wdata),
      .o_value   (freq2)
   );
   npsr_word_reg #(
      .RESET_VALUE ({16'h0000, `NPSR_RST_PHASE}),
      .WRITE_MASK  (32'h0000FFFF)
   ) u_phase2 (
      .i_ref_clk (i_ref_clk),
      .i_rstn    (i_rstn),
      .i_we      (we_word[1]),
      .i_be      (i_be),
      .i_wdata   (i_wdata),
      .o_value   (phase2)
   );
   npsr_word_reg #(
      .RESET_VALUE (`NPSR_RST_FREQ),
      .WRITE_MASK  (32'hFFFFFFFF)
   ) u_freq3 (
      .i_ref_clk (i_ref_clk),
      .i_rstn    (i_rstn),
      .i_we      (we_word[2]),
      .i_be      (i_be),
      .i_wdata   (i_wdata),
      .o_value   (freq3)
   );
   npsr_word_reg #(
      .RESET_VALUE ({16'h0000, `NPSR_RST_PHASE}),
      .WRITE_MASK  (32'h0000FFFF)
   ) u_phase3 (
      .i_ref_clk (i_ref_clk),
      .i_rstn    (i_rstn),
      .i_we      (we_word[3]),
      .i_be      (i_be),
      .i_wdata   (i_wdata),
      .o_value   (phase3)
   );

   // Supply control byte, low lane, only bits 5:4 writable
   always @* begin
      supply_d = supply_q;
      if (supply_hit && i_be[0]) begin
         supply_d = i_wdata[7:0] & `NPSR_SUPPLY_MASK;
      end
   end

   // Read mux
   always @* begin
      rdata_d = 32'h00000000;
      if (word_hit) begin
         case (word_sel)
            2'h0:    rdata_d = freq2;
            2'h1:    rdata_d = phase2;
            2'h2:    rdata_d = freq3;
            default: rdata_d = phase3;
         endcase
      end else if (i_addr == `NPSR_OFF_STARTUP) begin
         rdata_d[`NPSR_BIT_STARTUP_DONE] = init_sync_q;
      end else if (i_addr == `NPSR_OFF_VARIANT) begin
         rdata_d[`NPSR_VARIANT_MSB:0] = DIE_VARIANT;
      end else if (i_addr == `NPSR_OFF_SUPPLY) begin
         rdata_d[7:0] = supply_q;
      end
   end

   always @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         init_meta_q   <= 1'b0;
         init_sync_q   <= 1'b0;
         single_meta_q <= 1'b0;
         single_sync_q <= 1'b0;
         sel_meta_q    <= 2'h0;
         sel_sync_q    <= 2'h0;
         supply_q      <= `NPSR_RST_SUPPLY;
         o_rdata       <= 32'h00000000;
         o_rvalid      <= 1'b0;
         o_nco_freq_b_preset2  <= `NPSR_RST_FREQ;
         o_nco_phase_b_preset2 <= `NPSR_RST_PHASE;
         o_nco_freq_b_preset3  <= `NPSR_RST_FREQ;
         o_nco_phase_b_preset3 <= `NPSR_RST_PHASE;
         o_chan_b_presets_valid <= 1'b0;
         o_digital_core_supply_noise_suppress_en <= 1'b0;
         o_second_core_supply_noise_suppress_en  <= 1'b0;
      end else begin
         init_meta_q   <= i_init_done;
         init_sync_q   <= init_meta_q;
         single_meta_q <= i_single_channel;
         single_sync_q <= single_meta_q;
         sel_meta_q    <= i_preset_sel;
         sel_sync_q    <= sel_meta_q;
         supply_q      <= supply_d;
         o_rvalid      <= i_rd;
         if (i_rd) begin
            o_rdata <= rdata_d;
         end
         o_nco_freq_b_preset2  <= freq2;
         o_nco_phase_b_preset2 <= phase2[15:0];
         o_nco_freq_b_preset3  <= freq3;
         o_nco_phase_b_preset3 <= phase3[15:0];
         // Presets 2/3 in use only outside single-channel mode
         o_chan_b_presets_valid <= !single_sync_q && preset_hi;
         o_digital_core_supply_noise_suppress_en <= supply_q[`NPSR_BIT_DIGITAL_SUPPR];
         o_second_core_supply_noise_suppress_en  <= supply_q[`NPSR_BIT_SECOND_SUPPR];
      end
   end
endmodule
`default_nettype wire

// ==== npsr_consts.vh ====
// Constants for the oscillator preset and status register bank.
// Assumes byte addresses on the register port; multi-byte registers are little endian.
`ifndef NPSR_CONSTS_VH
`define NPSR_CONSTS_VH
`define NPSR_ADDR_W              12
`define NPSR_OFF_FREQ_B2         12'h250
`define NPSR_OFF_PHASE_B2        12'h254
`define NPSR_OFF_FREQ_B3         12'h258
`define NPSR_OFF_PHASE_B3        12'h25C
`define NPSR_OFF_STARTUP         12'h270
`define NPSR_OFF_VARIANT         12'h297
`define NPSR_OFF_SUPPLY          12'h2A2
`define NPSR_RST_FREQ            32'hC0000000
`define NPSR_RST_PHASE           16'h0000
`define NPSR_RST_SUPPLY          8'h00
`define NPSR_BIT_STARTUP_DONE    0
`define NPSR_BIT_DIGITAL_SUPPR   5
`define NPSR_BIT_SECOND_SUPPR    4
`define NPSR_VARIANT_MSB         4
`define NPSR_SUPPLY_MASK         8'h30
`define NPSR_VARIANT_MASK        8'h1F
`endif

// ==== npsr_word_reg.v ====
// One 32-bit register written per byte lane through byte enables.
// Assumes the write strobe and byte enables come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module npsr_word_reg #(
   parameter [31:0] RESET_VALUE = 32'h00000000,
   parameter [31:0] WRITE_MASK  = 32'hFFFFFFFF
) (
   // Clock and reset
   input  wire        i_ref_clk,
   input  wire        i_rstn,
   // Write port
   input  wire        i_we,
   input  wire [3:0]  i_be,
   input  wire [31:0] i_wdata,
   // Stored value
   output wire [31:0] o_value
);
   reg  [31:0] value_q;
   wire [31:0] value_d;
   genvar      g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_lane
         assign value_d[g*8+7:g*8] = (i_we && i_be[g]) ?
            (i_wdata[g*8+7:g*8] & WRITE_MASK[g*8+7:g*8]) : value_q[g*8+7:g*8];
      end
   endgenerate
   always @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         value_q <= RESET_VALUE;
      end else begin
         value_q <= value_d;
      end
   end
   assign o_value = value_q;
endmodule
`default_nettype wire

// ==== npsr_host.sv ====
// Host model: drives one-cycle strobes on the register port.
// Assumes the bank answers a read on the clock after the strobe.
`timescale 1ns/1ps
`default_nettype none
module npsr_host (
   // Clock and answer
   input  wire logic        i_ref_clk,
   input  wire logic        i_rvalid,
   input  wire logic [31:0] i_rdata,
   // Request: write, read, address, data, byte enables
   output var  logic [49:0] o_req
);
   initial o_req = '0;
   task automatic xfer(input logic [49:0] q, output logic [31:0] r);
      @(posedge i_ref_clk);
      #1 o_req = q;
      @(posedge i_ref_clk);
      #1 o_req = {2'b00, ~q[47:0]};
      r = i_rvalid ? i_rdata : 'x;
   endtask
endmodule
`default_nettype wire

// ==== npsr_regs_checker.sv ====
// Port assertions for the oscillator preset and status register bank.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module npsr_regs_checker #(
   parameter [4:0] DIE_VARIANT = 5'h15
) (
   input wire logic        i_ref_clk,
   input wire logic        i_rstn,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [11:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0]  i_be,
   input wire logic        i_init_done,
   input wire logic        i_single_channel,
   input wire logic [31:0] o_rdata,
   input wire logic [31:0] o_nco_freq_b_preset3,
   input wire logic [15:0] o_nco_phase_b_preset2,
   input wire logic [15:0] o_nco_phase_b_preset3,
   input wire logic        o_chan_b_presets_valid,
   input wire logic        o_digital_core_supply_noise_suppress_en,
   input wire logic        o_second_core_supply_noise_suppress_en
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   property p_rst;
      disable iff (1'b0) !i_rstn |=> o_nco_freq_b_preset3 == 32'hC0000000
         && o_nco_phase_b_preset3 == 16'h0000 && !o_digital_core_supply_noise_suppress_en;
   endproperty
   a_rst: assert property (p_rst) else $error("reset value wrong");
   property p_f3;
      i_wr && i_addr == 12'h258 && i_be == 4'hF |=> ##1 o_nco_freq_b_preset3 == $past(i_wdata, 2);
   endproperty
   a_f3: assert property (p_f3) else $error("preset 3 frequency wrong");
   property p_p2;
      i_wr && i_addr == 12'h254 && i_be[1:0] == 2'h3 |=> ##1
         o_nco_phase_b_preset2 == $past(i_wdata[15:0], 2);
   endproperty
   a_p2: assert property (p_p2) else $error("preset 2 phase wrong");
   property p_p3;
      i_wr && i_addr == 12'h25C && i_be[1:0] == 2'h3 |=> ##1
         o_nco_phase_b_preset3 == $past(i_wdata[15:0], 2);
   endproperty
   a_p3: assert property (p_p3) else $error("preset 3 phase wrong");
   property p_sup;
      i_wr && i_addr == 12'h2A2 && i_be[0] |=> ##1 {o_digital_core_supply_noise_suppress_en,
         o_second_core_supply_noise_suppress_en} == $past(i_wdata[5:4], 2);
   endproperty
   a_sup: assert property (p_sup) else $error("supply enables wrong");
   property p_var;
      i_rd && i_addr == 12'h297 |=> o_rdata[7:0] == {3'h0, DIE_VARIANT};
   endproperty
   a_var: assert property (p_var) else $error("variant code wrong");
   property p_init;
      i_rd && i_addr == 12'h270 && !i_init_done && !$past(i_init_done) |=> !o_rdata[0];
   endproperty
   a_init: assert property (p_init) else $error("startup flag early");
   property p_single;
      i_single_channel [*4] |-> !o_chan_b_presets_valid;
   endproperty
   a_single: assert property (p_single) else $error("presets used in single mode");
   c_wr: cover property (i_wr && i_be == 4'hF);
   c_flag: cover property (i_rd && i_addr == 12'h270 ##1 o_rdata[0]);
   c_single: cover property (i_single_channel [*4]);
endmodule
bind npsr_regs npsr_regs_checker #(.DIE_VARIANT(DIE_VARIANT)) u_chk (.i_ref_clk, .i_rstn,
   .i_wr, .i_rd, .i_addr, .i_wdata, .i_be, .i_init_done, .i_single_channel, .o_rdata,
   .o_nco_freq_b_preset3, .o_nco_phase_b_preset2, .o_nco_phase_b_preset3,
   .o_chan_b_presets_valid, .o_digital_core_supply_noise_suppress_en,
   .o_second_core_supply_noise_suppress_en);
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the oscillator preset and status register bank.
// Assumes npsr_host drives the register port and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        i_ref_clk, i_rstn, i_wr, i_rd, i_init_done, i_single_channel, o_rvalid;
   logic        vld, dsup, ssup;
   logic [1:0]  i_preset_sel;
   logic [3:0]  i_be, b;
   logic [11:0] i_addr, a;
   logic [15:0] p2, p3;
   logic [31:0] i_wdata, o_rdata, f2, f3, d, r, m [4];
   logic [7:0]  sup;
   logic [11:0] adr [8] = '{12'h250, 12'h254, 12'h258, 12'h25C, 12'h2A2, 12'h297, 12'h270, 12'h300};
   int          num_errors = 0;
   int          comparisons = 0;
   npsr_host host (.i_ref_clk, .i_rvalid(o_rvalid), .i_rdata(o_rdata),
      .o_req({i_wr, i_rd, i_addr, i_wdata, i_be}));
   // Variant value 5'h0B is arbitrary
   npsr_regs #(.DIE_VARIANT(5'h0B)) DUT (.i_ref_clk, .i_rstn, .i_wr, .i_rd, .i_addr, .i_wdata,
      .i_be, .o_rdata, .o_rvalid, .i_init_done, .i_single_channel, .i_preset_sel,
      .o_nco_freq_b_preset2(f2), .o_nco_phase_b_preset2(p2), .o_nco_freq_b_preset3(f3),
      .o_nco_phase_b_preset3(p3), .o_chan_b_presets_valid(vld),
      .o_digital_core_supply_noise_suppress_en(dsup),
      .o_second_core_supply_noise_suppress_en(ssup));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd(input logic [11:0] ad);
      host.xfer({2'b01, ad, 36'h0}, r);
   endtask
   task automatic cmp_out;
      check(f2, m[0]);
      check(32'(p2), m[1]);
      check(f3, m[2]);
      check(32'(p3), m[3]);
      check(32'(dsup), 32'(sup[5]));
      check(32'(ssup), 32'(sup[4]));
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      i_ref_clk = 1'b0;
      forever #10 i_ref_clk = ~i_ref_clk;
   end
   initial begin
      #200000;
      num_errors++;
      report_and_stop;
   end
   initial begin
      {i_rstn, i_init_done, i_single_channel, i_preset_sel} = '0;
      r = $urandom(32'h8BBE);
      m = '{32'hC0000000, 32'h0, 32'hC0000000, 32'h0};
      sup = 8'h00;
      repeat (12) @(posedge i_ref_clk);
      #1 i_rstn = 1'b1;
      cmp_out;
      rd(12'h270);
      check(r & 32'h1, 32'h0);
      i_init_done = 1'b1;
      for (int k = 0; k < 20 && r[0] !== 1'b1; k++) rd(12'h270);
      check(r & 32'h1, 32'h1);
      $display("test 1 done: reset values and startup flag");
      for (int i = 0; i < 48; i++) begin
         a = adr[i < 8 ? i : $urandom % 8];
         d = $urandom;
         b = i < 8 ? 4'hF : 4'($urandom);
         host.xfer({2'b10, a, d, b}, r);
         for (int k = 0; k < 4; k++)
            if (b[k] && a[11:4] == 8'h25) m[a[3:2]][8*k +: 8] = d[8*k +: 8];
         if (a[11:4] == 8'h25 && a[2]) m[a[3:2]][31:16] = 16'h0;
         if (a == 12'h2A2 && b[0]) sup = d[7:0] & 8'h30;
         rd(a);
         d = a[11:4] == 8'h25 ? m[a[3:2]] : a == 12'h2A2 ? {24'h0, sup} : 32'h0;
         d = a == 12'h297 ? 32'h0B : a == 12'h270 ? 32'h1 : d;
         check(a == 12'h270 ? r & 32'h1 : r, d);
         cmp_out;
      end
      $display("test 2 done: random register traffic");
      for (int i = 0; i < 8; i++) begin
         {i_single_channel, i_preset_sel} = 3'(i);
         repeat (4) @(posedge i_ref_clk);
         #1 check(32'(vld), 32'(i < 4 && i[1]));
      end
      $display("test 3 done: channel mode and preset select");
      i_rstn = 1'b0;
      repeat (3) @(posedge i_ref_clk);
      #1 i_rstn = 1'b1;
      m = '{32'hC0000000, 32'h0, 32'hC0000000, 32'h0};
      sup = 8'h00;
      cmp_out;
      $display("test 4 done: reset in mid run");
      report_and_stop;
   end
endmodule
`default_nettype wire
